// [dtc_datapath_config.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_datapath_config
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [1:0] transmitEnablePin,
  input wire logic calStartBit,
  output logic calLaunch,
  output logic offsetBinary,
  output logic sincCompensationOn,
  output logic gainStageOn,
  output logic [2:0] upsampleFactor,
  output logic [3:0] upsampleRatio,
  output logic auxConverterOn,
  output logic [7:0] datapathSetup,
  output logic [7:0] calibrationSeed,
  output logic [1:0] guardOutputPin
);
  logic [7:0] calSeed_reg;
  logic [7:0] calSeed_next;
  logic format_reg;
  logic format_next;
  logic sinc_reg;
  logic sinc_next;
  logic gain_reg;
  logic gain_next;
  logic [2:0] upsample_reg;
  logic [2:0] upsample_next;
  logic [3:0] ratio_reg;
  logic [3:0] ratio_next;
  logic [7:0] guardCtrl_reg;
  logic [7:0] guardCtrl_next;
  logic [7:0] riseFirst_reg;
  logic [7:0] riseFirst_next;
  logic [7:0] riseSecond_reg;
  logic [7:0] riseSecond_next;
  logic [7:0] fallFirst_reg;
  logic [7:0] fallFirst_next;
  logic [7:0] fallSecond_reg;
  logic [7:0] fallSecond_next;
  logic [7:0] setup_reg;
  logic [7:0] setup_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdValid_reg;
  logic rdValid_next;
  dtc_pkg::dtc_guard_cfg_t guardCfg;

  // Register writes
  always_comb
  begin
    calSeed_next = calSeed_reg;
    format_next = format_reg;
    sinc_next = sinc_reg;
    gain_next = gain_reg;
    upsample_next = upsample_reg;
    guardCtrl_next = guardCtrl_reg;
    riseFirst_next = riseFirst_reg;
    riseSecond_next = riseSecond_reg;
    fallFirst_next = fallFirst_reg;
    fallSecond_next = fallSecond_reg;
    setup_next = setup_reg;
    temp_next = temp_reg;
    if (regWrEn)
    begin
      case (regAddr)
        dtc_pkg::OFS_CAL_SEED: calSeed_next = regWrData;
        dtc_pkg::OFS_FORMAT:
          format_next = regWrData[dtc_pkg::BIT_FORMAT];
        dtc_pkg::OFS_FILTER:
        begin
          sinc_next = regWrData[dtc_pkg::BIT_SINC];
          gain_next = regWrData[dtc_pkg::BIT_GAIN];
        end
        dtc_pkg::OFS_UPSAMPLE: upsample_next = regWrData[2:0];
        dtc_pkg::OFS_GUARD: guardCtrl_next = {regWrData[7:4], 1'b0,
          regWrData[2:0]};
        dtc_pkg::OFS_RISE_FIRST: riseFirst_next = regWrData;
        dtc_pkg::OFS_RISE_SECOND: riseSecond_next = regWrData;
        dtc_pkg::OFS_FALL_FIRST: fallFirst_next = regWrData;
        dtc_pkg::OFS_FALL_SECOND: fallSecond_next = regWrData;
        dtc_pkg::OFS_SETUP: setup_next = regWrData;
        dtc_pkg::OFS_TEMP: temp_next = regWrData;
        default: setup_next = setup_reg;
      endcase
    end
    // Upsampling ratio from the factor code
    case (upsample_next)
      dtc_pkg::UP_1X: ratio_next = 4'h1;
      dtc_pkg::UP_2X: ratio_next = 4'h2;
      dtc_pkg::UP_4X: ratio_next = 4'h4;
      dtc_pkg::UP_8X: ratio_next = 4'h8;
      default: ratio_next = 4'h1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      calSeed_reg <= dtc_pkg::RST_CAL_SEED;
      format_reg <= 1'b0;
      sinc_reg <= 1'b0;
      gain_reg <= 1'b0;
      upsample_reg <= dtc_pkg::RST_UPSAMPLE;
      ratio_reg <= 4'h1;
      guardCtrl_reg <= {dtc_pkg::RST_FALL_STAGES, dtc_pkg::RST_RISE_STAGES,
        2'h0, dtc_pkg::RST_GUARD_RSVD};
      riseFirst_reg <= dtc_pkg::RST_RISE_FIRST;
      riseSecond_reg <= dtc_pkg::RST_RISE_SECOND;
      fallFirst_reg <= dtc_pkg::RST_FALL_FIRST;
      fallSecond_reg <= dtc_pkg::RST_FALL_SECOND;
      setup_reg <= dtc_pkg::RST_SETUP;
      temp_reg <= {dtc_pkg::RST_TEMP_RSVD, 1'b0};
    end
    else
    begin
      calSeed_reg <= calSeed_next;
      format_reg <= format_next;
      sinc_reg <= sinc_next;
      gain_reg <= gain_next;
      upsample_reg <= upsample_next;
      ratio_reg <= ratio_next;
      guardCtrl_reg <= guardCtrl_next;
      riseFirst_reg <= riseFirst_next;
      riseSecond_reg <= riseSecond_next;
      fallFirst_reg <= fallFirst_next;
      fallSecond_reg <= fallSecond_next;
      setup_reg <= setup_next;
      temp_reg <= temp_next;
    end
  end

  // Register reads, answered one cycle later
  always_comb
  begin
    rdValid_next = regRdEn;
    rdData_next = 8'h00;
    if (regRdEn)
    begin
      case (regAddr)
        dtc_pkg::OFS_CAL_SEED: rdData_next = calSeed_reg;
        dtc_pkg::OFS_FORMAT: rdData_next = {format_reg, 7'h00};
        dtc_pkg::OFS_FILTER: rdData_next = {sinc_reg, 1'b0, gain_reg, 5'h00};
        dtc_pkg::OFS_UPSAMPLE: rdData_next = {5'h00, upsample_reg};
        dtc_pkg::OFS_GUARD: rdData_next = guardCtrl_reg;
        dtc_pkg::OFS_RISE_FIRST: rdData_next = riseFirst_reg;
        dtc_pkg::OFS_RISE_SECOND: rdData_next = riseSecond_reg;
        dtc_pkg::OFS_FALL_FIRST: rdData_next = fallFirst_reg;
        dtc_pkg::OFS_FALL_SECOND: rdData_next = fallSecond_reg;
        dtc_pkg::OFS_SETUP: rdData_next = setup_reg;
        dtc_pkg::OFS_TEMP: rdData_next = temp_reg;
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  // Stage field value 3 is treated as two stages
  always_comb
  begin
    guardCfg.fallStages = guardCtrl_reg[7:6];
    guardCfg.riseStages = guardCtrl_reg[5:4];
    guardCfg.invert = guardCtrl_reg[dtc_pkg::BIT_INVERT];
    guardCfg.riseFirst = riseFirst_reg;
    guardCfg.riseSecond = riseSecond_reg;
    guardCfg.fallFirst = fallFirst_reg;
    guardCfg.fallSecond = fallSecond_reg;
  end

  generate
    for (genvar ch = 0; ch < dtc_pkg::CHANNELS; ch++)
    begin : g_guard
      dtc_guard_seq u_seq
      (
        .core_clk(core_clk),
        .resetn(resetn),
        .txen(transmitEnablePin[ch]),
        .cfg(guardCfg),
        .valid(),
        .guardPin(guardOutputPin[ch])
      );
    end
  endgenerate

  dtc_rise_detect u_cal_start
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .level(calStartBit),
    .pulse(calLaunch)
  );

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign offsetBinary = format_reg;
  assign sincCompensationOn = sinc_reg;
  assign gainStageOn = gain_reg;
  assign upsampleFactor = upsample_reg;
  assign upsampleRatio = ratio_reg;
  assign auxConverterOn = temp_reg[dtc_pkg::BIT_AUX];
  assign datapathSetup = setup_reg;
  assign calibrationSeed = calSeed_reg;

  // Register write and decode checks
  a_format_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_FORMAT) |=>
    offsetBinary == $past(regWrData[7]))
    else $error("Sample format bit not taken");
  a_sinc_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_FILTER) |=>
    sincCompensationOn == $past(regWrData[7]))
    else $error("Sinc compensation bit not taken");
  a_gain_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_FILTER) |=>
    gainStageOn == $past(regWrData[5]))
    else $error("Gain stage bit not taken");
  a_ratio_map: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (upsampleFactor == 3'h1) |-> upsampleRatio == 4'h2)
    else $error("Code 001 is not 2x");
  a_ratio_eight: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (upsampleFactor == 3'h4) |-> upsampleRatio == 4'h8)
    else $error("Code 100 is not 8x");
  a_aux_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_TEMP) |=>
    auxConverterOn == $past(regWrData[0]))
    else $error("Aux converter enable not taken");
  a_seed_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_CAL_SEED) |=>
    calibrationSeed == $past(regWrData))
    else $error("Calibration seed not taken");
  a_setup_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_SETUP) |=>
    datapathSetup == $past(regWrData))
    else $error("Datapath setup not taken");
  a_factor_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_UPSAMPLE) |=>
    upsampleFactor == $past(regWrData[2:0]))
    else $error("Upsample factor not taken");
  a_ratio_four: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (upsampleFactor == 3'h3) |-> upsampleRatio == 4'h4)
    else $error("Code 011 is not 4x");
  a_ratio_one: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (upsampleFactor == 3'h0) |-> upsampleRatio == 4'h1)
    else $error("Code 000 is not 1x");
  a_rise_stages: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_GUARD) |=>
    guardCfg.riseStages == $past(regWrData[5:4]))
    else $error("Rise stage count not taken");
  a_invert_write: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_GUARD) |=>
    guardCfg.invert == $past(regWrData[2]))
    else $error("Guard polarity bit not taken");
  a_rise_count: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_RISE_FIRST) |=>
    guardCfg.riseFirst == $past(regWrData))
    else $error("First rise count not taken");
  a_fall_count: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (regWrEn && regAddr == dtc_pkg::OFS_FALL_FIRST) |=>
    guardCfg.fallFirst == $past(regWrData))
    else $error("First fall count not taken");
  a_cal_single: assert property (@(posedge core_clk)
    disable iff (!resetn)
    calLaunch |=> !calLaunch)
    else $error("Calibration launch longer than one cycle");
endmodule
`default_nettype wire

// [dtc_guard_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_guard_seq
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic txen,
  input wire dtc_pkg::dtc_guard_cfg_t cfg,
  output logic valid,
  output logic guardPin
);
  typedef enum logic [1:0] {GS_IDLE, GS_FIRST, GS_SECOND} dtc_gs_state_t;

  dtc_gs_state_t state_reg;
  dtc_gs_state_t state_next;
  logic txenPrev_reg;
  logic txenPrev_next;
  logic rising_reg;
  logic rising_next;
  logic [12:0] count_reg;
  logic [12:0] count_next;
  logic valid_reg;
  logic valid_next;
  logic pin_reg;
  logic pin_next;
  logic edgeSeen;
  logic [1:0] edgeStages;
  logic [7:0] edgeFirst;
  logic [1:0] curStages;
  logic [7:0] curSecond;

  always_comb
  begin
    edgeSeen = (txen != txenPrev_reg);
    edgeStages = txen ? cfg.riseStages : cfg.fallStages;
    edgeFirst = txen ? cfg.riseFirst : cfg.fallFirst;
    curStages = rising_reg ? cfg.riseStages : cfg.fallStages;
    curSecond = rising_reg ? cfg.riseSecond : cfg.fallSecond;
    state_next = state_reg;
    txenPrev_next = txen;
    rising_next = rising_reg;
    count_next = count_reg;
    valid_next = valid_reg;
    if (edgeSeen)
    begin
      rising_next = txen;
      if (edgeStages == 2'h0)
      begin
        valid_next = txen;
        state_next = GS_IDLE;
      end
      else
      begin
        state_next = GS_FIRST;
        count_next = {edgeFirst, 5'h00};
      end
    end
    else
    begin
      case (state_reg)
        GS_IDLE:
        begin
          count_next = count_reg;
        end
        GS_FIRST:
        begin
          if (count_reg != 13'h0000)
            count_next = count_reg - 13'h0001;
          else if (curStages >= 2'h2)
          begin
            state_next = GS_SECOND;
            count_next = {curSecond, 5'h00};
          end
          else
          begin
            state_next = GS_IDLE;
            valid_next = rising_reg;
          end
        end
        GS_SECOND:
        begin
          if (count_reg != 13'h0000)
            count_next = count_reg - 13'h0001;
          else
          begin
            state_next = GS_IDLE;
            valid_next = rising_reg;
          end
        end
        default:
        begin
          state_next = GS_IDLE;
        end
      endcase
    end
    pin_next = valid_reg ^ cfg.invert;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg <= GS_IDLE;
      txenPrev_reg <= 1'b0;
      rising_reg <= 1'b0;
      count_reg <= 13'h0000;
      valid_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      txenPrev_reg <= txenPrev_next;
      rising_reg <= rising_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      pin_reg <= pin_next;
    end
  end

  assign valid = valid_reg;
  assign guardPin = pin_reg;

  a_stage_bypass: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (edgeSeen && edgeStages == 2'h0) |=> valid_reg == $past(txen))
    else $error("Zero stage edge did not pass at once");
  a_first_load: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (edgeSeen && edgeStages != 2'h0) |=>
    (state_reg == GS_FIRST && count_reg == {$past(edgeFirst), 5'h00}))
    else $error("First counter not loaded with 32 units");
  a_hold_first: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state_reg == GS_FIRST && count_reg != 13'h0000 && !edgeSeen) |=>
    $stable(valid_reg))
    else $error("Guard moved during first delay");
  a_chain_second: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state_reg == GS_FIRST && count_reg == 13'h0000 && !edgeSeen
    && curStages >= 2'h2) |=>
    (state_reg == GS_SECOND && count_reg == {$past(curSecond), 5'h00}))
    else $error("Second counter did not follow the first");
  a_second_end: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state_reg == GS_SECOND && count_reg == 13'h0000 && !edgeSeen) |=>
    (state_reg == GS_IDLE && valid_reg == $past(rising_reg)))
    else $error("Guard not settled after second delay");
  a_pin_polarity: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $stable(valid_reg) && $stable(cfg.invert) |=>
    pin_reg == ($past(valid_reg) ^ $past(cfg.invert)))
    else $error("Guard pin polarity wrong");
endmodule
`default_nettype wire

// [dtc_pkg.sv]
// What this block does
// - A rising edge of the calibration start bit launches calibration.
// - Format bit 7 picks two's complement (0) or offset binary (1).
// - Filter bit 7 switches sinc compensation in; resets off.
// - Filter bit 5 enables the gain stage; resets off.
// - Upsample field [2:0]: 000 is 1x, 011 is 4x, 100 is 8x; resets 000.
// - Rise stage count [5:4] sets how many counters delay the guard rise.
// - Polarity bit 2 clear: pin high when valid; set: high when invalid.
// - First rise counter delays rise 32 times its value; resets 0x0f.
// - Second rise counter adds 32 times its value; resets zero.
// - First fall counter delays fall 32 times its value; values below 0x12 are not clamped.
// - Second fall counter adds 32 times its value before the fall.
// - Temperature bit 0 powers the auxiliary converter; resets off.
package dtc_pkg;
  localparam logic [11:0] OFS_CAL_SEED = 12'h0ed;
  localparam logic [11:0] OFS_FORMAT = 12'h110;
  localparam logic [11:0] OFS_FILTER = 12'h111;
  localparam logic [11:0] OFS_UPSAMPLE = 12'h112;
  localparam logic [11:0] OFS_GUARD = 12'h11f;
  localparam logic [11:0] OFS_RISE_FIRST = 12'h121;
  localparam logic [11:0] OFS_RISE_SECOND = 12'h122;
  localparam logic [11:0] OFS_FALL_FIRST = 12'h123;
  localparam logic [11:0] OFS_FALL_SECOND = 12'h124;
  localparam logic [11:0] OFS_SETUP = 12'h12d;
  localparam logic [11:0] OFS_TEMP = 12'h12f;

  localparam int BIT_FORMAT = 7;
  localparam int BIT_SINC = 7;
  localparam int BIT_GAIN = 5;
  localparam int BIT_INVERT = 2;
  localparam int BIT_AUX = 0;

  localparam logic [7:0] RST_CAL_SEED = 8'ha6;
  localparam logic [1:0] RST_FALL_STAGES = 2'h2;
  localparam logic [1:0] RST_RISE_STAGES = 2'h0;
  localparam logic [1:0] RST_GUARD_RSVD = 2'h3;
  localparam logic [7:0] RST_RISE_FIRST = 8'h0f;
  localparam logic [7:0] RST_RISE_SECOND = 8'h00;
  localparam logic [7:0] RST_FALL_FIRST = 8'hff;
  localparam logic [7:0] RST_FALL_SECOND = 8'hff;
  localparam logic [7:0] RST_SETUP = 8'h46;
  localparam logic [6:0] RST_TEMP_RSVD = 7'h10;
  localparam logic [2:0] RST_UPSAMPLE = 3'h0;

  localparam logic [2:0] UP_1X = 3'h0;
  localparam logic [2:0] UP_2X = 3'h1;
  localparam logic [2:0] UP_4X = 3'h3;
  localparam logic [2:0] UP_8X = 3'h4;

  // Cycles per delay unit is 32, a shift of 5
  localparam int UNIT_SHIFT = 5;
  localparam int CHANNELS = 2;

  typedef struct packed {
    logic [1:0] riseStages;
    logic [1:0] fallStages;
    logic invert;
    logic [7:0] riseFirst;
    logic [7:0] riseSecond;
    logic [7:0] fallFirst;
    logic [7:0] fallSecond;
  } dtc_guard_cfg_t;
endpackage

// [dtc_rise_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_rise_detect
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic level,
  output logic pulse
);
  logic prev_reg;
  logic prev_next;
  logic pulse_reg;
  logic pulse_next;

  always_comb
  begin
    prev_next = level;
    pulse_next = level & ~prev_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      prev_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;

  a_start_edge: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (level && !$past(level) && $past(resetn)) |=> pulse_reg)
    else $error("Start edge did not launch");
endmodule
`default_nettype wire

// [dtc_txen_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host driving the transmit enable pins, with an optional lag in cycles
module dtc_txen_host
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] wantLevel,
  input wire logic [1:0] lagCycles,
  output logic [1:0] pinLevel
);
  logic [1:0] lagCnt;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pinLevel <= 2'h0;
      lagCnt <= 2'h0;
    end
    else if (wantLevel == pinLevel)
      lagCnt <= 2'h0;
    else if (lagCnt >= lagCycles)
      pinLevel <= wantLevel;
    else
      lagCnt <= lagCnt + 2'h1;
  end
endmodule
`default_nettype wire

// [test_dtc_datapath_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dtc_datapath_config;
  logic core_clk = 0;
  logic resetn = 0;
  logic regWrEn = 0;
  logic regRdEn = 0;
  logic [11:0] regAddr = 0;
  logic [7:0] regWrData = 0;
  logic calStartBit = 0;
  logic [1:0] wantLevel = 0;
  logic [1:0] lagCycles = 0;
  logic [1:0] transmitEnablePin;
  logic [7:0] regRdData;
  logic regRdValid, calLaunch, offsetBinary, sincCompensationOn;
  logic gainStageOn, auxConverterOn;
  logic [2:0] upsampleFactor;
  logic [3:0] upsampleRatio;
  logic [7:0] datapathSetup, calibrationSeed;
  logic [1:0] guardOutputPin;
  int error_cnt = 0;
  int n_tests = 0;
  int mdl [12];
  // Last entry is an unmapped address
  localparam logic [11:0] ADDRS [12] = '{12'h0ed, 12'h110, 12'h111,
    12'h112, 12'h11f, 12'h121, 12'h122, 12'h123, 12'h124, 12'h12d,
    12'h12f, 12'h120};
  localparam logic [7:0] RSTV [12] = '{8'ha6, 8'h00, 8'h00, 8'h00,
    8'h83, 8'h0f, 8'h00, 8'hff, 8'hff, 8'h46, 8'h20, 8'h00};
  localparam logic [7:0] WMSK [12] = '{8'hff, 8'h80, 8'ha0, 8'h07,
    8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};

  always #12.5 core_clk = ~core_clk;

  dtc_txen_host dtc_txen_host_inst (.core_clk(core_clk), .resetn(resetn),
    .wantLevel(wantLevel), .lagCycles(lagCycles),
    .pinLevel(transmitEnablePin));

  dtc_datapath_config dtc_datapath_config_inst (.core_clk(core_clk),
    .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .transmitEnablePin(transmitEnablePin),
    .calStartBit(calStartBit), .calLaunch(calLaunch),
    .offsetBinary(offsetBinary), .sincCompensationOn(sincCompensationOn),
    .gainStageOn(gainStageOn), .upsampleFactor(upsampleFactor),
    .upsampleRatio(upsampleRatio), .auxConverterOn(auxConverterOn),
    .datapathSetup(datapathSetup), .calibrationSeed(calibrationSeed),
    .guardOutputPin(guardOutputPin));

  task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(int i, logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= ADDRS[i];
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    mdl[i] = d & WMSK[i];
    #1;
  endtask

  task automatic rd(int i);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= ADDRS[i];
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    check(regRdValid, 1'b1, "read valid");
    check(regRdData, mdl[i][7:0], "read data");
  endtask

  function automatic logic [3:0] ratio(logic [2:0] c);
    case (c)
      3'h1: return 4'h2;
      3'h3: return 4'h4;
      3'h4: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction

  function automatic int dly(int s, int a, int b);
    return s == 0 ? 2 : s == 1 ? 32 * a + 3 : 32 * (a + b) + 4;
  endfunction

  task automatic outs();
    check(offsetBinary, mdl[1][7], "format");
    check(sincCompensationOn, mdl[2][7], "sinc");
    check(gainStageOn, mdl[2][5], "gain");
    check(upsampleFactor, mdl[3][2:0], "factor");
    check(upsampleRatio, ratio(mdl[3][2:0]), "ratio");
    check(auxConverterOn, mdl[10][0], "aux");
    check(datapathSetup, mdl[9][7:0], "setup");
    check(calibrationSeed, mdl[0][7:0], "seed");
  endtask

  task automatic gcfg(int f, int r, logic inv);
    wr(4, {f[1:0], r[1:0], 1'b0, inv, 2'h3});
  endtask

  task automatic guard(int ch, logic lvl, logic inv, int exp);
    int n;
    wantLevel[ch] <= lvl;
    n = 0;
    while (transmitEnablePin[ch] !== lvl && n < 10)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    while (guardOutputPin[ch] !== (lvl ^ inv) && n < 30000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, exp, "guard delay");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(60000 * 25);
    error_cnt++;
    close_out();
  end

  initial
  begin
    logic [7:0] d;
    int n;
    int r1;
    void'($urandom(68584));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i++)
      mdl[i] = RSTV[i];
    #1;
    outs();
    for (int i = 0; i < 12; i++)
      rd(i);
    $display("test reset values done");
    repeat (4)
    begin
      for (int i = 0; i < 12; i++)
      begin
        d = 8'($urandom);
        if (i == 4)
          d[1:0] = 2'h3;
        if (i == 4 && (d[7:6] == 2'h0 || d[7:6] == 2'h3))
          d[7:6] = 2'h1;
        if (i == 10)
          d[7:1] = 7'h10;
        if (i == 7 && d < 8'h12)
          d = 8'h12;
        wr(i, d);
      end
      for (int i = 0; i < 12; i++)
        rd(i);
      outs();
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(3, 8'(c));
      outs();
    end
    wr(0, 8'ha2);
    wr(9, 8'h8b);
    wr(10, 8'h21);
    outs();
    $display("test register access done");
    @(posedge core_clk);
    calStartBit <= 1'b1;
    n = 0;
    repeat (6)
    begin
      @(posedge core_clk);
      #1;
      n += calLaunch;
    end
    check(n, 1, "cal pulse");
    @(posedge core_clk);
    calStartBit <= 1'b0;
    n = 0;
    repeat (4)
    begin
      @(posedge core_clk);
      #1;
      n += calLaunch;
    end
    check(n, 0, "cal on fall");
    $display("test calibration done");
    for (int ch = 0; ch < 2; ch++)
    begin
      lagCycles <= 2'(ch * 3);
      r1 = 1 + $urandom % 4;
      wr(5, 8'(r1));
      wr(6, 8'h03);
      wr(7, 8'h12);
      wr(8, 8'h01);
      gcfg(1, 0, 1'b0);
      guard(ch, 1'b1, 1'b0, dly(0, 0, 0));
      guard(ch, 1'b0, 1'b0, dly(1, 18, 1));
      gcfg(2, 1, 1'b0);
      guard(ch, 1'b1, 1'b0, dly(1, r1, 3));
      guard(ch, 1'b0, 1'b0, dly(2, 18, 1));
      gcfg(2, 2, 1'b0);
      guard(ch, 1'b1, 1'b0, dly(2, r1, 3));
      gcfg(1, 3, 1'b1);
      guard(ch, 1'b0, 1'b1, dly(1, 18, 1));
      guard(ch, 1'b1, 1'b1, dly(2, r1, 3));
      gcfg(1, 1, 1'b0);
      wantLevel[ch] <= 1'b0;
      repeat (100) @(posedge core_clk);
      wantLevel[ch] <= 1'b1;
      n = 0;
      repeat (700)
      begin
        @(posedge core_clk);
        #1;
        n += !guardOutputPin[ch];
      end
      check(n, 0, "guard restart");
      $display("test guard channel %0d done", ch);
    end
    close_out();
  end
endmodule
`default_nettype wire
